// ===== design/srcsel_top.sv
// reference source selector: register port, priority table and automatic selection
//
// Contract
// (R1) forced value not all-zero or all-one selects that port number directly
// (R2) all-zero or all-one forced value gives automatic priority selection
// (R3) forced value resets to all ones, so start is automatic
// (R4) 4-bit priority per port, two per register, lower value ranks higher
// (R5) priority 0000 or 1111 excludes the port from automatic choice
// (R6) equal priorities order first-in first-out by validation time
// (R7) failed head of equal group yields to next; returning port queues behind
// (R8) automatic picks best available source, falling down the table on failure
// (R9) revertive: higher-ranked newly valid source takes over
// (R10) non-revertive: keep source, flag revalidation, interrupt unless masked
// (R11) non-revertive: higher valid source present means no change, lock kept
// (R12) only lower valid sources left: failure of selected always switches
// (R13) software pulses revertive bit to move to revalidated higher source
// (R14) fast switching bit: brief inactivity sets alarm and switches reference
// (R15) fast inactivity may raise interrupt instead of or besides switching
// (R16) interrupt status bit 14 flags fast inactivity of locked reference
// (R17) monitor bit 6 drives the lost-source bit onto the test data output
// (R18) mirrored bit holds the pin high until software clears it
// (R19) mirroring is off after reset
// (R20) loss of signal, activity, regularity or frequency makes source unavailable
// (R21) frequency checked only on regular, present clocks
// (R22) phase anomalies on selected source fill bucket; threshold crossing rejects it
// (R23) sources assessed per 128 ms, one fill per faulty period
// (R24) empty bucket alarms after threshold/8 seconds, default 0.75 s
`include "srcsel_cfg.svh"
`default_nettype none
module srcsel_top
	import srcsel_pkg::*;
#(
	parameter int NUM_REFS = 4,
	parameter int PERIOD_CYC = `SRCSEL_PERIOD_MS * `SRCSEL_CLK_KHZ,
	parameter int FAST_CYC = `SRCSEL_FAST_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// reference inputs and monitor results
	input wire logic [NUM_REFS-1:0] ref_clk_pin,
	input wire logic [NUM_REFS-1:0] ref_los_pin,
	input wire logic [NUM_REFS-1:0] freq_oob,
	input wire logic [NUM_REFS-1:0] phase_anom,
	// selection result
	output logic [3:0] sel_port,
	output logic sel_locked,
	output logic irq,
	// test data output sharing
	input wire logic jtag_tdo,
	input wire logic jtag_tdo_oe,
	output logic tdo_out,
	output logic tdo_oe
);
	localparam int IW = (NUM_REFS > 1) ? $clog2(NUM_REFS) : 1;
	localparam int PW = $clog2(PERIOD_CYC);

	logic [1:0] rst_sync_ff;
	logic rst_i_n;
	logic [3:0] ref_sel_ff;
	srcsel_pri_t pri_ff [NUM_REFS];
	logic [7:0] ctrl_ff;
	logic [7:0] upper_ff;
	logic [7:0] lower_ff;
	logic [7:0] size_ff;
	logic [1:0] decay_ff;
	logic [NUM_REFS-1:0] reval_mask_ff;
	logic [NUM_REFS-1:0] reval_ff;
	logic main_fail_ff;
	logic [PW-1:0] period_cnt_ff;
	logic tick_ff;
	srcsel_stamp_t seq_ff;
	srcsel_stamp_t stamp_ff [NUM_REFS];
	logic [NUM_REFS-1:0] valid_d_ff;
	logic [IW-1:0] sel_ff;
	logic has_sel_ff;
	logic was_forced_ff;
	logic [15:0] rdata_ff;
	logic [3:0] sel_port_ff;
	logic sel_locked_ff;
	logic irq_ff;
	logic tdo_out_ff;
	logic tdo_oe_ff;

	logic [NUM_REFS-1:0] avail;
	logic [NUM_REFS-1:0] fast_dead;
	logic [NUM_REFS-1:0] eligible;
	logic [NUM_REFS-1:0] rising;
	logic [NUM_REFS-1:0] outranks;
	logic [IW-1:0] best;
	logic best_ok;
	logic any_higher;
	logic [IW-1:0] nxt_sel;
	logic nxt_has_sel;
	srcsel_mode_t mode;
	logic wr_int;
	logic wr_reval;

	// ==========================================================
	// reset release
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) rst_sync_ff <= 2'b00;
		else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	assign rst_i_n = rst_sync_ff[1];

	// ==========================================================
	// configuration registers
	always_ff @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			ref_sel_ff <= `SRCSEL_REF_SEL_RST; // R3
			ctrl_ff <= `SRCSEL_CTRL_RST; // R19
			upper_ff <= `SRCSEL_UPPER_RST;
			lower_ff <= `SRCSEL_LOWER_RST;
			size_ff <= `SRCSEL_SIZE_RST;
			decay_ff <= `SRCSEL_DECAY_RST;
			reval_mask_ff <= '0;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`SRCSEL_OFS_REF_SEL: ref_sel_ff <= reg_wdata[3:0];
				`SRCSEL_OFS_CTRL: ctrl_ff <= reg_wdata[7:0];
				`SRCSEL_OFS_UPPER: upper_ff <= reg_wdata[7:0];
				`SRCSEL_OFS_LOWER: lower_ff <= reg_wdata[7:0];
				`SRCSEL_OFS_SIZE: size_ff <= reg_wdata[7:0];
				`SRCSEL_OFS_DECAY: decay_ff <= reg_wdata[1:0];
				`SRCSEL_OFS_REVAL_MASK: reval_mask_ff <= reg_wdata[NUM_REFS-1:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// per-port priorities, two nibbles per register, and monitors
	genvar g;
	generate
		for (g = 0; g < NUM_REFS; g++) begin : g_ref
			srcsel_mon_if mi ();

			always_ff @(posedge clock or negedge rst_i_n) begin
				if (!rst_i_n) pri_ff[g] <= `SRCSEL_PRI_RST;
				else if (reg_wr && reg_addr == 8'(`SRCSEL_OFS_PRI_BASE + g / 2))
					pri_ff[g] <= reg_wdata[4 * (g % 2) +: 4]; // R4
			end

			// stamp taken when the port becomes valid keeps equal groups in arrival order
			always_ff @(posedge clock or negedge rst_i_n) begin
				if (!rst_i_n) stamp_ff[g] <= 8'h00;
				else if (rising[g]) stamp_ff[g] <= seq_ff; // R6 R7
			end

			assign mi.upper = upper_ff;
			assign mi.lower = lower_ff;
			assign mi.size = size_ff;
			assign mi.decay = decay_ff;
			assign mi.fast_en = ctrl_ff[`SRCSEL_CTRL_FAST_EN];
			assign mi.fast_alarm_en = ctrl_ff[`SRCSEL_CTRL_FAST_SW]; // R15
			assign mi.selected = has_sel_ff && (sel_ff == IW'(g));
			assign mi.tick = tick_ff;
			assign avail[g] = mi.avail;
			assign fast_dead[g] = mi.fast_dead;
			assign eligible[g] = avail[g] && pri_ff[g] != 4'h0 && pri_ff[g] != 4'hf; // R5
			assign rising[g] = eligible[g] && !valid_d_ff[g];

			srcsel_mon #(
				.FAST_CYC(FAST_CYC)
			) u_mon (
				.clock(clock),
				.rst_n(rst_i_n),
				.ref_pin(ref_clk_pin[g]),
				.los_pin(ref_los_pin[g]),
				.freq_oob(freq_oob[g]),
				.phase_anom(phase_anom[g]),
				.m(mi.mon)
			);
		end
	endgenerate

	// ==========================================================
	// assessment period tick and arrival sequence
	always_ff @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			period_cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else if (period_cnt_ff == PW'(PERIOD_CYC - 1)) begin
			period_cnt_ff <= '0;
			tick_ff <= 1'b1; // R23
		end else begin
			period_cnt_ff <= period_cnt_ff + 1'b1;
			tick_ff <= 1'b0;
		end
	end

	// the sequence wraps after 256 validations; ties then may reorder once
	always_ff @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			seq_ff <= 8'h00;
			valid_d_ff <= '0;
		end else begin
			valid_d_ff <= eligible;
			if (|rising) seq_ff <= seq_ff + 8'h01;
		end
	end

	// ==========================================================
	// ranking: lower priority value first, then earlier stamp
	function automatic logic ahead(input srcsel_pri_t pa, input srcsel_stamp_t sa,
		input srcsel_pri_t pb, input srcsel_stamp_t sb);
		ahead = (pa < pb) || (pa == pb && sa < sb);
	endfunction

	always_comb begin
		best = '0;
		best_ok = 1'b0;
		for (int i = 0; i < NUM_REFS; i++) begin
			if (eligible[i] && (!best_ok
				|| ahead(pri_ff[i], stamp_ff[i], pri_ff[best], stamp_ff[best]))) begin
				best = IW'(i); // R8
				best_ok = 1'b1;
			end
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_REFS; i++) begin
			// only a strictly better value outranks; equal ones wait their turn
			outranks[i] = eligible[i] && has_sel_ff && IW'(i) != sel_ff
				&& pri_ff[i] < pri_ff[sel_ff]; // R7
		end
		any_higher = |outranks;
	end

	// ==========================================================
	// selection decision
	assign mode = (ref_sel_ff != 4'h0 && ref_sel_ff != 4'hf) ? SRCSEL_FORCED : SRCSEL_AUTO; // R2

	always_comb begin
		nxt_sel = sel_ff;
		nxt_has_sel = has_sel_ff;
		unique case (mode)
			SRCSEL_FORCED: begin
				nxt_has_sel = ({28'h0, ref_sel_ff} <= NUM_REFS); // R1
				nxt_sel = IW'(ref_sel_ff - 4'h1);
			end
			SRCSEL_AUTO: begin
				// leaving forced mode ranks afresh instead of holding the forced port
				if (ctrl_ff[`SRCSEL_CTRL_REVERT] || !has_sel_ff || was_forced_ff) begin
					nxt_sel = best; // R9 R13
					nxt_has_sel = best_ok;
				end else if (!eligible[sel_ff] && !any_higher) begin
					// a failed source with no better one waiting gives way to the best one left
					nxt_sel = best; // R12
					nxt_has_sel = best_ok;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			sel_ff <= '0;
			has_sel_ff <= 1'b0;
			was_forced_ff <= 1'b0;
		end else begin
			sel_ff <= nxt_sel; // R11
			has_sel_ff <= nxt_has_sel;
			was_forced_ff <= (mode == SRCSEL_FORCED); // R2
		end
	end

	// ==========================================================
	// status flags: a hardware set wins over a same-cycle clear
	assign wr_reval = reg_wr && reg_addr == `SRCSEL_OFS_REVAL_STS;
	assign wr_int = reg_wr && reg_addr == `SRCSEL_OFS_INT;

	always_ff @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) reval_ff <= '0;
		else begin
			for (int i = 0; i < NUM_REFS; i++) begin
				if (rising[i] && outranks[i] && mode == SRCSEL_AUTO
					&& !ctrl_ff[`SRCSEL_CTRL_REVERT]) reval_ff[i] <= 1'b1; // R10
				else if (wr_reval && reg_wdata[i]) reval_ff[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) main_fail_ff <= 1'b0;
		else if (ctrl_ff[`SRCSEL_CTRL_FAST_EN] && has_sel_ff && fast_dead[sel_ff])
			main_fail_ff <= 1'b1; // R16
		else if (wr_int && reg_wdata[`SRCSEL_INT_MAIN_FAIL]) main_fail_ff <= 1'b0; // R18
	end

	// ==========================================================
	// outputs
	always_ff @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			sel_port_ff <= 4'h0;
			sel_locked_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			sel_port_ff <= has_sel_ff ? 4'(sel_ff) + 4'h1 : 4'h0;
			sel_locked_ff <= has_sel_ff; // R11
			irq_ff <= |(reval_ff & ~reval_mask_ff) // R10
				|| (main_fail_ff && ctrl_ff[`SRCSEL_CTRL_FAST_IRQ]); // R15
		end
	end

	// mirroring only when asked, so boundary scan works untouched by default
	always_ff @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			tdo_out_ff <= 1'b0;
			tdo_oe_ff <= 1'b0;
		end else if (ctrl_ff[`SRCSEL_CTRL_TDO_FLAG]) begin
			tdo_out_ff <= main_fail_ff; // R17 R18
			tdo_oe_ff <= 1'b1;
		end else begin
			tdo_out_ff <= jtag_tdo; // R19
			tdo_oe_ff <= jtag_tdo_oe;
		end
	end

	// ==========================================================
	// register read: data stand one cycle, zero otherwise and on unmapped offsets
	always_ff @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) rdata_ff <= 16'h0000;
		else if (!reg_rd) rdata_ff <= 16'h0000;
		else begin
			rdata_ff <= 16'h0000;
			unique case (reg_addr)
				`SRCSEL_OFS_REF_SEL: rdata_ff <= {12'h000, ref_sel_ff};
				`SRCSEL_OFS_CTRL: rdata_ff <= {8'h00, ctrl_ff};
				`SRCSEL_OFS_UPPER: rdata_ff <= {8'h00, upper_ff};
				`SRCSEL_OFS_LOWER: rdata_ff <= {8'h00, lower_ff};
				`SRCSEL_OFS_SIZE: rdata_ff <= {8'h00, size_ff};
				`SRCSEL_OFS_DECAY: rdata_ff <= {14'h0000, decay_ff};
				`SRCSEL_OFS_REVAL_MASK: rdata_ff <= 16'(reval_mask_ff);
				`SRCSEL_OFS_REVAL_STS: rdata_ff <= 16'(reval_ff);
				`SRCSEL_OFS_VALID_STS: rdata_ff <= 16'(eligible);
				`SRCSEL_OFS_INT: rdata_ff <= 16'(main_fail_ff) << `SRCSEL_INT_MAIN_FAIL;
				`SRCSEL_OFS_SEL_STS: rdata_ff <= {11'h000, has_sel_ff, sel_port_ff};
				default: begin
					for (int i = 0; i < NUM_REFS; i += 2) begin
						if (reg_addr == 8'(`SRCSEL_OFS_PRI_BASE + i / 2)) begin
							rdata_ff[3:0] <= pri_ff[i];
							if (i + 1 < NUM_REFS) rdata_ff[7:4] <= pri_ff[(i + 1) % NUM_REFS];
						end
					end
				end
			endcase
		end
	end

	assign reg_rdata = rdata_ff;
	assign sel_port = sel_port_ff;
	assign sel_locked = sel_locked_ff;
	assign irq = irq_ff;
	assign tdo_out = tdo_out_ff;
	assign tdo_oe = tdo_oe_ff;
endmodule
`default_nettype wire

// ===== design/srcsel_cfg.svh
// register offsets, field positions, reset values and timing counts of the source selector
`ifndef SRCSEL_CFG_SVH
`define SRCSEL_CFG_SVH

// ==========================================================
// register offsets (8-bit address)
`define SRCSEL_OFS_INT 8'h05
`define SRCSEL_OFS_REF_SEL 8'h30
`define SRCSEL_OFS_PRI_BASE 8'h31
`define SRCSEL_OFS_REVAL_MASK 8'h33
`define SRCSEL_OFS_REVAL_STS 8'h34
`define SRCSEL_OFS_VALID_STS 8'h35
`define SRCSEL_OFS_SEL_STS 8'h36
`define SRCSEL_OFS_CTRL 8'h48
`define SRCSEL_OFS_UPPER 8'h50
`define SRCSEL_OFS_LOWER 8'h51
`define SRCSEL_OFS_SIZE 8'h52
`define SRCSEL_OFS_DECAY 8'h53

// ==========================================================
// field positions
`define SRCSEL_CTRL_REVERT 0
`define SRCSEL_CTRL_FAST_SW 1
`define SRCSEL_CTRL_FAST_IRQ 2
`define SRCSEL_CTRL_FAST_EN 5
`define SRCSEL_CTRL_TDO_FLAG 6
`define SRCSEL_INT_MAIN_FAIL 14
`define SRCSEL_SEL_LOCKED 4

// ==========================================================
// reset values
`define SRCSEL_REF_SEL_RST 4'hf
`define SRCSEL_PRI_RST 4'h0
`define SRCSEL_CTRL_RST 8'h00
`define SRCSEL_UPPER_RST 8'h06
`define SRCSEL_LOWER_RST 8'h04
`define SRCSEL_SIZE_RST 8'h08
`define SRCSEL_DECAY_RST 2'h1

// ==========================================================
// timing
`define SRCSEL_CLK_KHZ 25000
`define SRCSEL_PERIOD_MS 128
`define SRCSEL_FAST_CYC 64

`endif

// ===== design/srcsel_pkg.sv
// types shared by the source selector modules
`default_nettype none
package srcsel_pkg;
	typedef logic [3:0] srcsel_pri_t;
	typedef logic [7:0] srcsel_stamp_t;
	typedef enum logic {SRCSEL_AUTO, SRCSEL_FORCED} srcsel_mode_t;
endpackage
`default_nettype wire

// ===== design/srcsel_mon_if.sv
// link between the selector core and one per-source quality monitor
`default_nettype none
interface srcsel_mon_if;
	logic [7:0] upper;
	logic [7:0] lower;
	logic [7:0] size;
	logic [1:0] decay;
	logic fast_en;
	logic fast_alarm_en;
	logic selected;
	logic tick;
	logic avail;
	logic fast_dead;
	modport ctl (output upper, lower, size, decay, fast_en, fast_alarm_en, selected, tick,
		input avail, fast_dead);
	modport mon (input upper, lower, size, decay, fast_en, fast_alarm_en, selected, tick,
		output avail, fast_dead);
endinterface
`default_nettype wire

// ===== design/srcsel_mon.sv
// per-source activity, leaky-bucket and frequency qualification monitor
`include "srcsel_cfg.svh"
`default_nettype none
module srcsel_mon
	import srcsel_pkg::*;
#(
	parameter int FAST_CYC = `SRCSEL_FAST_CYC
) (
	// clock and synchronised reset
	input wire logic clock,
	input wire logic rst_n,
	// source pins and monitor inputs
	input wire logic ref_pin,
	input wire logic los_pin,
	input wire logic freq_oob,
	input wire logic phase_anom,
	// core link
	srcsel_mon_if.mon m
);
	logic [2:0] ref_sync_ff;
	logic [2:0] los_sync_ff;
	logic ref_lvl_ff;
	logic los_ff;
	logic [$clog2(FAST_CYC+1)-1:0] fast_cnt_ff;
	logic seen_edge_ff;
	logic anom_ff;
	logic [7:0] bucket_ff;
	logic [2:0] leak_cnt_ff;
	logic alarm_ff;
	logic freq_bad_ff;
	logic avail_ff;
	logic ref_edge;
	logic fault;

	// ==========================================================
	// pin synchronisers: a change counts once stages two and three agree
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ref_sync_ff <= 3'h0;
			los_sync_ff <= 3'h0;
			ref_lvl_ff <= 1'b0;
			los_ff <= 1'b0;
		end else begin
			ref_sync_ff <= {ref_sync_ff[1:0], ref_pin};
			los_sync_ff <= {los_sync_ff[1:0], los_pin};
			if (ref_sync_ff[1] == ref_sync_ff[2]) ref_lvl_ff <= ref_sync_ff[2];
			if (los_sync_ff[1] == los_sync_ff[2]) los_ff <= los_sync_ff[2];
		end
	end

	assign ref_edge = (ref_sync_ff[1] == ref_sync_ff[2]) && (ref_sync_ff[2] != ref_lvl_ff);

	// ==========================================================
	// fast inactivity: FAST_CYC clock cycles without a reference edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) fast_cnt_ff <= '0;
		else if (ref_edge) fast_cnt_ff <= '0;
		else if (fast_cnt_ff != FAST_CYC[$bits(fast_cnt_ff)-1:0]) fast_cnt_ff <= fast_cnt_ff + 1'b1;
	end
	assign m.fast_dead = (fast_cnt_ff == FAST_CYC[$bits(fast_cnt_ff)-1:0]);

	// ==========================================================
	// per-period fault collection
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			seen_edge_ff <= 1'b0;
			anom_ff <= 1'b0;
		end else if (m.tick) begin
			seen_edge_ff <= ref_edge;
			anom_ff <= phase_anom && m.selected;
		end else begin
			if (ref_edge) seen_edge_ff <= 1'b1;
			if (phase_anom && m.selected) anom_ff <= 1'b1; // R22
		end
	end
	assign fault = !seen_edge_ff || anom_ff;

	// ==========================================================
	// leaky bucket: one fill per faulty period, a leak only when no fill
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bucket_ff <= 8'h00;
			leak_cnt_ff <= 3'h0;
		end else if (m.tick) begin
			if (fault) begin
				if (bucket_ff < m.size) bucket_ff <= bucket_ff + 8'h01; // R23
				leak_cnt_ff <= 3'h0;
			end else if (leak_cnt_ff >= 3'((4'h1 << m.decay) - 4'h1)) begin
				leak_cnt_ff <= 3'h0;
				if (bucket_ff != 8'h00) bucket_ff <= bucket_ff - 8'h01;
			end else begin
				leak_cnt_ff <= leak_cnt_ff + 3'h1;
			end
		end
	end

	// ==========================================================
	// alarm: set at the upper threshold, clear below the lower one
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) alarm_ff <= 1'b0;
		else if (bucket_ff >= m.upper) alarm_ff <= 1'b1; // R24 R22
		else if (m.fast_en && m.fast_alarm_en && m.fast_dead) alarm_ff <= 1'b1; // R14
		else if (bucket_ff < m.lower) alarm_ff <= 1'b0;
	end

	// frequency result is only trusted on a regular, present clock
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) freq_bad_ff <= 1'b0;
		else if (!alarm_ff && !los_ff) freq_bad_ff <= freq_oob; // R21
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) avail_ff <= 1'b0;
		else avail_ff <= !los_ff && !alarm_ff && !freq_bad_ff
			&& !(m.fast_en && m.fast_alarm_en && m.fast_dead); // R20
	end
	assign m.avail = avail_ff;
endmodule
`default_nettype wire

// ===== tb/srcsel_ref_model.sv
// reference clock sources that can be stopped one by one
`default_nettype none
module srcsel_ref_model (
	// per-source run control
	input wire logic [3:0] run,
	// clock pins toward the selector
	output logic [3:0] pins
);
	timeunit 1ns;
	timeprecision 1ps;
	initial pins = 4'h0;
	// ==========================================================
	// sources
	// distinct half periods keep sources out of phase with the master clock;
	// a stopped source stands still at its last level
	for (genvar i = 0; i < 4; i++) begin : g_src
		always begin
			#(90 + 17 * i);
			if (run[i]) pins[i] = ~pins[i];
		end
	end
endmodule
`default_nettype wire

// ===== tb/srcsel_top_monitor.sv
// port-level assertions for the source selector
`default_nettype none
module srcsel_top_monitor
	import srcsel_pkg::*;
#(
	parameter int NUM_REFS = 4,
	parameter int PERIOD_CYC = 64,
	parameter int FAST_CYC = 16
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// selection and test pin
	input wire logic [3:0] sel_port,
	input wire logic sel_locked,
	input wire logic irq,
	input wire logic jtag_tdo,
	input wire logic jtag_tdo_oe,
	input wire logic tdo_out,
	input wire logic tdo_oe
);
	// ==========================================================
	// shadow of what software wrote
	logic [2:0] rs_ff;
	logic [3:0] fsel_ff, q_ff, ps;
	logic [15:0] pri_ff;
	logic mir_ff, w30_ff, all_ex;
	wire live = rs_ff[2];
	wire auto_m = fsel_ff inside {4'h0, 4'hf};
	wire clr14 = reg_wr && reg_addr == 8'h05 && reg_wdata[14];
	assign ps = 4'(pri_ff >> {sel_port - 4'h1, 2'b00});
	// the design sees reset leave two edges late; outputs before that are reset values
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) rs_ff <= 3'h0;
		else rs_ff <= {rs_ff[1:0], 1'b1};
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fsel_ff <= 4'hf;
			pri_ff <= 16'h0000;
			mir_ff <= 1'b0;
			w30_ff <= 1'b0;
			q_ff <= 4'h0;
		end else begin
			if (reg_wr && reg_addr == 8'h30) fsel_ff <= reg_wdata[3:0];
			if (reg_wr && reg_addr == 8'h30) w30_ff <= 1'b1;
			if (reg_wr && reg_addr == 8'h31) pri_ff[7:0] <= reg_wdata[7:0];
			if (reg_wr && reg_addr == 8'h32) pri_ff[15:8] <= reg_wdata[7:0];
			if (reg_wr && reg_addr == 8'h48) mir_ff <= reg_wdata[6];
			if (reg_wr) q_ff <= 4'h0;
			else if (q_ff != 4'hf) q_ff <= q_ff + 4'h1;
		end
	end
	always_comb begin
		all_ex = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (!(pri_ff[4*i+:4] inside {4'h0, 4'hf})) all_ex = 1'b0;
		end
	end
	// ==========================================================
	// assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	chk_rst_forced: assert property (reg_rd && reg_addr == 8'h30 && !w30_ff
		|=> reg_rdata == 16'h000f) else $error("forced value not all ones after reset");
	chk_forced_port: assert property (live && q_ff == 4'hf && fsel_ff inside {[1:NUM_REFS]}
		|-> sel_port == fsel_ff) else $error("forced port not selected");
	chk_none_excl: assert property (live && q_ff == 4'hf && auto_m && all_ex
		|-> sel_port == 4'h0) else $error("excluded port selected");
	chk_auto_usable: assert property (live && q_ff == 4'hf && auto_m && sel_port != 4'h0
		|-> !(ps inside {4'h0, 4'hf})) else $error("auto picked unusable priority");
	chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside its cycle");
	chk_pri_read: assert property (reg_rd && reg_addr inside {8'h31, 8'h32} |=>
		reg_rdata == {8'h00, $past(reg_addr[0]) ? pri_ff[7:0] : pri_ff[15:8]})
		else $error("priority readback wrong");
	chk_tdo_pass: assert property (live && $past(live) && !$past(mir_ff) |->
		tdo_out == $past(jtag_tdo) && tdo_oe == $past(jtag_tdo_oe))
		else $error("test output not passed through");
	chk_tdo_drive: assert property (live && $past(mir_ff) |-> tdo_oe)
		else $error("mirrored flag not driven");
	chk_tdo_hold: assert property ($past(mir_ff) && mir_ff && tdo_out && !$past(clr14)
		|=> tdo_out) else $error("mirrored flag dropped without clear");
	chk_lock_flag: assert property (sel_locked == (sel_port != 4'h0))
		else $error("lock indication disagrees with port");
	chk_irq_hold: assert property (irq && !reg_wr && !$past(reg_wr) |=> irq)
		else $error("interrupt dropped without software");
	cover property (live && fsel_ff inside {[1:NUM_REFS]} && sel_port == fsel_ff);
	cover property ($past(mir_ff) && tdo_out);
	cover property ($rose(irq));
endmodule
bind srcsel_top srcsel_top_monitor #(
	.NUM_REFS(NUM_REFS), .PERIOD_CYC(PERIOD_CYC), .FAST_CYC(FAST_CYC)
) i_mon (
	.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sel_port(sel_port),
	.sel_locked(sel_locked), .irq(irq), .jtag_tdo(jtag_tdo), .jtag_tdo_oe(jtag_tdo_oe),
	.tdo_out(tdo_out), .tdo_oe(tdo_oe)
);
`default_nettype wire

// ===== tb/reference_source_selector_tb_top.sv
// self-checking bench for the source selector
`default_nettype none
module reference_source_selector_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
	logic jtag_tdo = 1'b0, jtag_tdo_oe = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic [3:0] run = 4'hf, los = 4'h0, oob = 4'h0, anom = 4'h0, pins, sel_port;
	logic sel_locked, irq, tdo_out, tdo_oe;
	logic [15:0] q[$];
	int err_total = 0, checks = 0, n = 0, seed = 11031;
	// ==========================================================
	// design and sources
	srcsel_top #(.NUM_REFS(4), .PERIOD_CYC(64), .FAST_CYC(16)) i_dut (
		.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_clk_pin(pins),
		.ref_los_pin(los), .freq_oob(oob), .phase_anom(anom), .sel_port(sel_port),
		.sel_locked(sel_locked), .irq(irq), .jtag_tdo(jtag_tdo), .jtag_tdo_oe(jtag_tdo_oe),
		.tdo_out(tdo_out), .tdo_oe(tdo_oe)
	);
	srcsel_ref_model i_src (.run(run), .pins(pins));
	always #20 clock = ~clock;
	always @(posedge clock) {jtag_tdo, jtag_tdo_oe} <= 2'($random(seed));
	// read data stands only in the cycle after the strobe
	always @(posedge clock) rd_d <= reg_rd;
	always @(negedge clock) if (rd_d) chk(reg_rdata, q.pop_front());
	// ==========================================================
	// tasks
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic close_out;
		if (err_total == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		q.push_back(e);
		@(posedge clock);
		reg_rd <= 1'b0;
	endtask
	task automatic wait_sel(input logic [3:0] v);
		for (n = 0; n < 3000 && sel_port !== v; n++) @(negedge clock);
		chk(16'(sel_port), 16'(v));
		if (n == 3000) close_out;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		rd(8'h30, 16'h000f);
		rd(8'h48, 16'h0000);
		rd(8'h7e, 16'h0000);
		rd(8'h31, 16'h0000);
		rd(8'h50, 16'h0006);
		repeat (200) @(negedge clock);
		chk(16'(sel_port), 16'h0000);
		wr(8'h31, 16'h0021);
		wr(8'h32, 16'h0043);
		rd(8'h31, 16'h0021);
		wait_sel(4'h1);
		rd(8'h36, 16'h0011);
		for (int v = 1; v <= 5; v++) begin
			wr(8'h30, 16'(v % 5));
			wait_sel(v == 5 ? 4'h1 : 4'(v));
			repeat (20) @(negedge clock);
		end
		// silent source: bucket alarm after six faulty periods
		run[0] = 1'b0;
		wait_sel(4'h2);
		chk(16'(n >= 320 && n <= 464), 16'h0001);
		run[0] = 1'b1;
		repeat (1200) @(negedge clock);
		chk(16'(sel_port), 16'h0002);
		chk(16'(irq), 16'h0001);
		rd(8'h34, 16'h0001);
		@(posedge clock) los[1] <= 1'b1;
		repeat (200) @(negedge clock);
		chk({11'h0, sel_locked, sel_port}, 16'h0012);
		wr(8'h48, 16'h0001);
		wait_sel(4'h1);
		@(posedge clock) los[1] <= 1'b0;
		wr(8'h34, 16'h000f);
		wr(8'h48, 16'h0000);
		repeat (4) @(negedge clock);
		chk(16'(irq), 16'h0000);
		// masked revalidation after a frequency fault
		@(posedge clock) oob[0] <= 1'b1;
		wait_sel(4'h2);
		wr(8'h33, 16'h0001);
		@(posedge clock) oob[0] <= 1'b0;
		repeat (20) @(negedge clock);
		rd(8'h34, 16'h0001);
		chk(16'(irq), 16'h0000);
		wr(8'h34, 16'h0001);
		wr(8'h33, 16'h0000);
		wr(8'h48, 16'h0001);
		wait_sel(4'h1);
		wr(8'h48, 16'h0000);
		// equal priorities
		wr(8'h31, 16'h0011);
		@(posedge clock) los[0] <= 1'b1;
		wait_sel(4'h2);
		@(posedge clock) los[0] <= 1'b0;
		repeat (100) @(negedge clock);
		chk(16'(sel_port), 16'h0002);
		@(posedge clock) los[1] <= 1'b1;
		wait_sel(4'h1);
		@(posedge clock) los[1] <= 1'b0;
		wr(8'h31, 16'h0021);
		// steady phase anomalies on the selected source fill its bucket
		@(posedge clock) anom <= 4'h1;
		wait_sel(4'h2);
		@(posedge clock) anom <= 4'h0;
		wr(8'h48, 16'h0001);
		wait_sel(4'h1);
		wr(8'h34, 16'h000f);
		// fast inactivity with switch, interrupt and mirror
		wr(8'h48, 16'h0066);
		run[0] = 1'b0;
		wait_sel(4'h2);
		chk(16'(n < 40), 16'h0001);
		repeat (3) @(negedge clock);
		chk({14'h0, irq, tdo_out & tdo_oe}, 16'h0003);
		rd(8'h05, 16'h4000);
		wr(8'h05, 16'h4000);
		repeat (3) @(negedge clock);
		chk(16'(tdo_out), 16'h0000);
		wr(8'h48, 16'h0000);
		run[0] = 1'b1;
		repeat (20) @(negedge clock);
		close_out;
	end
endmodule
`default_nettype wire
